// ---- hw/smbat_defs.svh ----
// Purpose: named constants of the alert and timeout block
// Assumes: included by bare name from the top design file only
// Notes: times stay in their own unit, cycle counts are derived
`ifndef SMBAT_DEFS_SVH
`define SMBAT_DEFS_SVH

`define SMBAT_CLK_HZ 40000000
`define SMBAT_MS_PER_S 1000

// clock low timeout window, ms
`define SMBAT_TIMEOUT_MIN_MS 6'h19
`define SMBAT_TIMEOUT_MAX_MS 6'h23
// cumulative stretch budgets, ms
`define SMBAT_SEXT_MS 6'h19
`define SMBAT_SEXT_GUARD_MS 6'h01
`define SMBAT_MEXT_MS 6'h0a
`define SMBAT_MS_MAX 6'h3f

// command codes and addresses
`define SMBAT_CMD_CLEAR_FAULT 8'h03
`define SMBAT_CMD_ALERT_MASK 8'hd8
`define SMBAT_ARA_ADDR 7'h0c
`define SMBAT_MASK_RESET 16'h0000
`define SMBAT_READ_FILL 8'h00

// address pin level codes and decode bases
`define SMBAT_PIN_OPEN 2'h0
`define SMBAT_PIN_LOW 2'h1
`define SMBAT_PIN_HIGH 2'h2
`define SMBAT_RANK_OPEN 5'h00
`define SMBAT_RANK_LOW 5'h01
`define SMBAT_RANK_HIGH 5'h02
`define SMBAT_RANK_W2 5'h09
`define SMBAT_RANK_W1 5'h03
`define SMBAT_ADDR_GRP0 7'h40
`define SMBAT_ADDR_GRP1 7'h10
`define SMBAT_ADDR_GRP2 7'h50
`define SMBAT_IDX_GRP1 5'h08
`define SMBAT_IDX_GRP2 5'h10

// byte framing
`define SMBAT_BITS_PER_BYTE 4'h8
`define SMBAT_LAST_BIT 4'h7
`define SMBAT_IDX_ADDR 2'h0
`define SMBAT_IDX_CMD 2'h1
`define SMBAT_IDX_LO 2'h2
`define SMBAT_IDX_HI 2'h3

`endif

// ---- hw/smbat_pkg.sv ----
// Purpose: types shared by the alert and timeout block
// Assumes: nothing
// Notes: constants live in smbat_defs.svh
package smbat_pkg;

    typedef enum logic [2:0] {
        SMBAT_IDLE  = 3'b000,
        SMBAT_RX    = 3'b001,
        SMBAT_RXACK = 3'b010,
        SMBAT_TX    = 3'b011,
        SMBAT_TXACK = 3'b100
    } smbat_state_e;

    typedef logic [5:0] smbat_ms_t;

endpackage : smbat_pkg

// ---- hw/smbat_tick.sv ----
// Purpose: one-cycle millisecond enable from the system clock
// Assumes: CYCLES of at least two
// Notes: free running from reset
`timescale 1ns/100ps
module smbat_tick #(
    parameter int CYCLES = 40000
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    localparam int W = $clog2(CYCLES);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb
    begin
        if (cnt_ff == W'(CYCLES - 1))
        begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
        end
        else
        begin
            nxt_cnt = cnt_ff + W'(1);
            nxt_tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule : smbat_tick

// ---- hw/smbat_top.sv ----
// Purpose: smbus slave alert masking, timeout and stretch budget
// Assumes: open-drain pins resolved outside; fault and busy are local
// Notes: registers reached only over the smbus link
// Contract
// - clock low past 25 ms resets link
// - slave stretching per message within 25 ms
// - over budget releases lines, returns idle
// - alert gated by mask register and auto mask
// - arbitrate address during alert response read
// - winner stops driving alert after read
// - shared alert ends after last responder
// - won response read auto-masks active faults
// - auto masking leaves fault status untouched
// - auto mask cleared only by clear fault
// - address from three tri-level pins, 27 choices
`timescale 1ns/100ps
`include "smbat_defs.svh"
module smbat_top #(
    parameter int CYCLES_PER_MS = `SMBAT_CLK_HZ / `SMBAT_MS_PER_S,
    parameter logic [15:0] MASK_RESET = `SMBAT_MASK_RESET
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic alert_request_line_out,
    output logic alert_request_line_oe_n,
    input wire logic [1:0] addr_sel_pin_0,
    input wire logic [1:0] addr_sel_pin_1,
    input wire logic [1:0] addr_sel_pin_2,
    input wire logic [15:0] fault_active,
    input wire logic core_busy,
    output logic clear_fault_pulse,
    output logic [15:0] alert_suppress_mask,
    output logic [15:0] auto_ack_suppress,
    output logic bus_timeout_pulse,
    output logic stretch_abort_pulse
);
    // two-stage synchronisers, third stage only for edges
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;
    logic [5:0] adr_s1_ff, adr_s2_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            adr_s1_ff <= 6'h00;
            adr_s2_ff <= 6'h00;
        end
        else
        begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff <= sda_s2_ff;
            adr_s1_ff <= {addr_sel_pin_2, addr_sel_pin_1, addr_sel_pin_0};
            adr_s2_ff <= adr_s1_ff;
        end
    end

    logic tick;

    smbat_tick #(
        .CYCLES(CYCLES_PER_MS)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    function automatic logic [4:0] smbat_rank(input logic [1:0] lvl);
        logic [4:0] r;
        r = `SMBAT_RANK_OPEN;
        if (lvl == `SMBAT_PIN_LOW)
            r = `SMBAT_RANK_LOW;
        else if (lvl == `SMBAT_PIN_HIGH)
            r = `SMBAT_RANK_HIGH;
        return r;
    endfunction : smbat_rank

    logic [4:0] adr_idx;
    logic [6:0] own_addr;

    always_comb
    begin
        adr_idx = 5'(smbat_rank(adr_s2_ff[5:4]) * `SMBAT_RANK_W2)
                + 5'(smbat_rank(adr_s2_ff[3:2]) * `SMBAT_RANK_W1)
                + smbat_rank(adr_s2_ff[1:0]);
        if (adr_idx < `SMBAT_IDX_GRP1)
            own_addr = `SMBAT_ADDR_GRP0 + 7'(adr_idx);
        else if (adr_idx < `SMBAT_IDX_GRP2)
            own_addr = `SMBAT_ADDR_GRP1 + 7'(adr_idx - `SMBAT_IDX_GRP1);
        else
            own_addr = `SMBAT_ADDR_GRP2 + 7'(adr_idx - `SMBAT_IDX_GRP2);
    end

    smbat_pkg::smbat_state_e state_ff, nxt_state;
    logic [3:0] bitcnt_ff, nxt_bitcnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] tx_ff, nxt_tx;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [7:0] lo_ff, nxt_lo;
    logic [1:0] idx_ff, nxt_idx;
    logic is_read_ff, nxt_is_read;
    logic is_ara_ff, nxt_is_ara;
    logic acked_ff, nxt_acked;
    logic in_msg_ff, nxt_in_msg;
    logic sda_oe_n_ff, nxt_sda_oe_n;
    logic scl_oe_n_ff, nxt_scl_oe_n;
    smbat_pkg::smbat_ms_t low_ms_ff, nxt_low_ms;
    smbat_pkg::smbat_ms_t ext_ms_ff, nxt_ext_ms;
    logic [15:0] mask_ff, nxt_mask;
    logic [15:0] auto_ff, nxt_auto;
    logic alert_oe_n_ff, nxt_alert_oe_n;
    logic clr_ff, nxt_clr;
    logic to_ff, nxt_to;
    logic abort_ff, nxt_abort;

    logic scl_rise, scl_fall, start_cond, stop_cond, busy_link;

    assign scl_rise = scl_s2_ff & ~scl_d_ff;
    assign scl_fall = ~scl_s2_ff & scl_d_ff;
    assign start_cond = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
    assign stop_cond = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;
    assign busy_link = in_msg_ff | (state_ff != smbat_pkg::SMBAT_IDLE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_cmd = cmd_ff;
        nxt_lo = lo_ff;
        nxt_idx = idx_ff;
        nxt_is_read = is_read_ff;
        nxt_is_ara = is_ara_ff;
        nxt_acked = acked_ff;
        nxt_in_msg = in_msg_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        nxt_scl_oe_n = scl_oe_n_ff;
        nxt_low_ms = low_ms_ff;
        nxt_ext_ms = ext_ms_ff;
        nxt_mask = mask_ff;
        nxt_auto = auto_ff;
        nxt_clr = 1'b0;
        nxt_to = 1'b0;
        nxt_abort = 1'b0;

        if (scl_s2_ff)
            nxt_low_ms = '0;
        else if (tick && low_ms_ff != `SMBAT_MS_MAX)
            nxt_low_ms = low_ms_ff + 6'h01;
        if (tick && !scl_oe_n_ff && ext_ms_ff != `SMBAT_MS_MAX)
            nxt_ext_ms = ext_ms_ff + 6'h01;
        if (!scl_oe_n_ff && !core_busy)
            nxt_scl_oe_n = 1'b1;

        if (start_cond)
        begin
            nxt_state = smbat_pkg::SMBAT_RX;
            nxt_bitcnt = 4'h0;
            nxt_idx = `SMBAT_IDX_ADDR;
            nxt_is_ara = 1'b0;
            nxt_sda_oe_n = 1'b1;
            if (!in_msg_ff)
                nxt_ext_ms = '0;
            nxt_in_msg = 1'b1;
        end
        else if (stop_cond)
        begin
            nxt_state = smbat_pkg::SMBAT_IDLE;
            nxt_in_msg = 1'b0;
            nxt_sda_oe_n = 1'b1;
            nxt_scl_oe_n = 1'b1;
            nxt_ext_ms = '0;
        end
        else if (busy_link && low_ms_ff > `SMBAT_TIMEOUT_MIN_MS)
        begin
            nxt_state = smbat_pkg::SMBAT_IDLE;
            nxt_in_msg = 1'b0;
            nxt_sda_oe_n = 1'b1;
            nxt_scl_oe_n = 1'b1;
            nxt_ext_ms = '0;
            nxt_to = 1'b1;
        end
        else if (busy_link
                 && ext_ms_ff >= `SMBAT_SEXT_MS - `SMBAT_SEXT_GUARD_MS)
        begin
            nxt_state = smbat_pkg::SMBAT_IDLE;
            nxt_in_msg = 1'b0;
            nxt_sda_oe_n = 1'b1;
            nxt_scl_oe_n = 1'b1;
            nxt_ext_ms = '0;
            nxt_abort = 1'b1;
        end
        else if (scl_rise)
        begin
            unique case (state_ff)
                smbat_pkg::SMBAT_RX:
                begin
                    nxt_shift = {shift_ff[6:0], sda_s2_ff};
                    nxt_bitcnt = bitcnt_ff + 4'h1;
                end
                smbat_pkg::SMBAT_TX:
                begin
                    if (sda_oe_n_ff && !sda_s2_ff)
                    begin
                        nxt_state = smbat_pkg::SMBAT_IDLE;
                        nxt_sda_oe_n = 1'b1;
                    end
                    else
                    begin
                        nxt_tx = {tx_ff[6:0], 1'b0};
                        nxt_bitcnt = bitcnt_ff + 4'h1;
                        if (is_ara_ff && bitcnt_ff == `SMBAT_LAST_BIT)
                            nxt_auto = auto_ff | fault_active;
                    end
                end
                smbat_pkg::SMBAT_TXACK:
                    nxt_acked = ~sda_s2_ff;
                default:
                    nxt_state = state_ff;
            endcase
        end
        else if (scl_fall)
        begin
            unique case (state_ff)
                smbat_pkg::SMBAT_RX:
                begin
                    if (bitcnt_ff == `SMBAT_BITS_PER_BYTE)
                    begin
                        nxt_state = smbat_pkg::SMBAT_RXACK;
                        nxt_sda_oe_n = 1'b0;
                        if (idx_ff != `SMBAT_IDX_HI)
                            nxt_idx = idx_ff + 2'h1;
                        unique case (idx_ff)
                            `SMBAT_IDX_ADDR:
                            begin
                                nxt_is_read = shift_ff[0];
                                if (shift_ff[7:1] == own_addr)
                                    nxt_tx = (cmd_ff == `SMBAT_CMD_ALERT_MASK)
                                           ? mask_ff[7:0] : `SMBAT_READ_FILL;
                                // answer response read with own address
                                else if (shift_ff[7:1] == `SMBAT_ARA_ADDR
                                         && shift_ff[0] && !alert_oe_n_ff)
                                begin
                                    nxt_is_ara = 1'b1;
                                    nxt_tx = {own_addr, 1'b0};
                                end
                                else
                                begin
                                    nxt_state = smbat_pkg::SMBAT_IDLE;
                                    nxt_sda_oe_n = 1'b1;
                                end
                            end
                            `SMBAT_IDX_CMD:
                            begin
                                nxt_cmd = shift_ff;
                                if (shift_ff == `SMBAT_CMD_CLEAR_FAULT)
                                begin
                                    nxt_auto = 16'h0000;
                                    nxt_clr = 1'b1;
                                end
                            end
                            `SMBAT_IDX_LO:
                                nxt_lo = shift_ff;
                            `SMBAT_IDX_HI:
                            begin
                                if (cmd_ff == `SMBAT_CMD_ALERT_MASK)
                                    nxt_mask = {shift_ff, lo_ff};
                            end
                        endcase
                    end
                end
                smbat_pkg::SMBAT_RXACK:
                begin
                    nxt_sda_oe_n = 1'b1;
                    nxt_bitcnt = 4'h0;
                    // stretch only while core is busy
                    if (core_busy)
                        nxt_scl_oe_n = 1'b0;
                    if (is_read_ff)
                    begin
                        nxt_state = smbat_pkg::SMBAT_TX;
                        nxt_sda_oe_n = tx_ff[7];
                    end
                    else
                        nxt_state = smbat_pkg::SMBAT_RX;
                end
                smbat_pkg::SMBAT_TX:
                begin
                    if (bitcnt_ff == `SMBAT_BITS_PER_BYTE)
                    begin
                        nxt_sda_oe_n = 1'b1;
                        nxt_state = smbat_pkg::SMBAT_TXACK;
                    end
                    else
                        nxt_sda_oe_n = tx_ff[7];
                end
                smbat_pkg::SMBAT_TXACK:
                begin
                    if (acked_ff && !is_ara_ff)
                    begin
                        nxt_tx = (cmd_ff == `SMBAT_CMD_ALERT_MASK)
                               ? mask_ff[15:8] : `SMBAT_READ_FILL;
                        nxt_sda_oe_n = nxt_tx[7];
                        nxt_bitcnt = 4'h0;
                        nxt_state = smbat_pkg::SMBAT_TX;
                    end
                    else
                    begin
                        nxt_sda_oe_n = 1'b1;
                        nxt_state = smbat_pkg::SMBAT_IDLE;
                    end
                end
                default:
                    nxt_state = state_ff;
            endcase
        end

        // auto mask drops alert once won
        nxt_alert_oe_n = ~|(fault_active & ~mask_ff & ~auto_ff);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= smbat_pkg::SMBAT_IDLE;
            bitcnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            cmd_ff <= 8'h00;
            lo_ff <= 8'h00;
            idx_ff <= 2'h0;
            is_read_ff <= 1'b0;
            is_ara_ff <= 1'b0;
            acked_ff <= 1'b0;
            in_msg_ff <= 1'b0;
            sda_oe_n_ff <= 1'b1;
            scl_oe_n_ff <= 1'b1;
            low_ms_ff <= '0;
            ext_ms_ff <= '0;
            mask_ff <= MASK_RESET;
            auto_ff <= 16'h0000;
            alert_oe_n_ff <= 1'b1;
            clr_ff <= 1'b0;
            to_ff <= 1'b0;
            abort_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            cmd_ff <= nxt_cmd;
            lo_ff <= nxt_lo;
            idx_ff <= nxt_idx;
            is_read_ff <= nxt_is_read;
            is_ara_ff <= nxt_is_ara;
            acked_ff <= nxt_acked;
            in_msg_ff <= nxt_in_msg;
            sda_oe_n_ff <= nxt_sda_oe_n;
            scl_oe_n_ff <= nxt_scl_oe_n;
            low_ms_ff <= nxt_low_ms;
            ext_ms_ff <= nxt_ext_ms;
            mask_ff <= nxt_mask;
            auto_ff <= nxt_auto;
            alert_oe_n_ff <= nxt_alert_oe_n;
            clr_ff <= nxt_clr;
            to_ff <= nxt_to;
            abort_ff <= nxt_abort;
        end
    end

    // open-drain: data always low, enable decides
    logic zero_ff;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            zero_ff <= 1'b0;
        else
            zero_ff <= 1'b0;
    end

    assign scl_out = zero_ff;
    assign sda_out = zero_ff;
    assign alert_request_line_out = zero_ff;
    assign scl_oe_n = scl_oe_n_ff;
    assign sda_oe_n = sda_oe_n_ff;
    assign alert_request_line_oe_n = alert_oe_n_ff;
    assign clear_fault_pulse = clr_ff;
    assign alert_suppress_mask = mask_ff;
    assign auto_ack_suppress = auto_ff;
    assign bus_timeout_pulse = to_ff;
    assign stretch_abort_pulse = abort_ff;

endmodule : smbat_top

// ---- test/smbat_host.sv ----
// Purpose: smbus host model for the link
// Assumes: both lines pulled up in the bench
// Notes: 200 ns bit period; waits out a stretched clock
`timescale 1ns/100ps
module smbat_host (
    input wire logic scl,
    input wire logic sda,
    output logic scl_rel,
    output logic sda_rel
);
    localparam int HP = 100;

    initial
    begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic rise();
        int n;
        n = 0;
        scl_rel = 1'b1;
        while (!scl && n < 2000)
        begin
            #25;
            n++;
        end
        #HP;
    endtask : rise

    task automatic bit_io(input logic b, output logic r);
        #(HP / 2);
        sda_rel = b;
        #(HP / 2);
        rise();
        r = sda;
        scl_rel = 1'b0;
    endtask : bit_io

    task automatic xfer(input logic [7:0] d, input logic a,
        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r[i]);
        end
        bit_io(a, ack);
    endtask : xfer

    task automatic start();
        #(HP / 2);
        sda_rel = 1'b1;
        #(HP / 2);
        rise();
        sda_rel = 1'b0;
        #HP;
        scl_rel = 1'b0;
    endtask : start

    task automatic stop();
        #(HP / 2);
        sda_rel = 1'b0;
        #(HP / 2);
        rise();
        sda_rel = 1'b1;
        #HP;
    endtask : stop
endmodule : smbat_host

// ---- test/smbat_properties.sv ----
// Purpose: port checks of the alert and timeout block
// Assumes: CYCLES_PER_MS equals that of the bound instance
// Notes: bind statement at the foot
`timescale 1ns/100ps
module smbat_checker #(
    parameter int CYCLES_PER_MS = 40000
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic alert_request_line_oe_n,
    input wire logic [15:0] fault_active,
    input wire logic clear_fault_pulse,
    input wire logic [15:0] alert_suppress_mask,
    input wire logic [15:0] auto_ack_suppress,
    input wire logic bus_timeout_pulse,
    input wire logic stretch_abort_pulse
);
    localparam int MS = CYCLES_PER_MS;
    logic [31:0] low_ff;
    logic [31:0] nxt_low;
    logic [31:0] st_ff;
    logic [31:0] nxt_st;
    logic [1:0] run_ff;
    logic [1:0] nxt_run;
    logic sda_d_ff;
    logic [15:0] open_src;

    assign open_src = fault_active & ~alert_suppress_mask & ~auto_ack_suppress;

    // low time of the wire, own stretch per message
    always_comb
    begin
        nxt_low = scl_in ? 32'h0 : low_ff + 32'h1;
        nxt_st = st_ff + {31'h0, !scl_oe_n};
        if (scl_in && sda_in && !sda_d_ff)
        begin
            nxt_st = 32'h0;
        end
        nxt_run = (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_ff <= 32'h0;
            st_ff <= 32'h0;
            run_ff <= 2'h0;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            low_ff <= nxt_low;
            st_ff <= nxt_st;
            run_ff <= nxt_run;
            sda_d_ff <= sda_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_release;
        scl_oe_n && sda_oe_n;
    endsequence

    property p_alert_gate;
        run_ff == 2'h3 |-> !alert_request_line_oe_n == $past(|open_src);
    endproperty
    a_alert_gate: assert property (p_alert_gate)
        else $error("alert level disagrees with masked faults");

    property p_auto_set;
        auto_ack_suppress != $past(auto_ack_suppress) &&
        auto_ack_suppress != 16'h0000
        |-> auto_ack_suppress == ($past(auto_ack_suppress) |
            $past(fault_active));
    endproperty
    a_auto_set: assert property (p_auto_set)
        else $error("auto mask set to wrong bits");

    property p_auto_hold;
        ($past(auto_ack_suppress) & ~auto_ack_suppress) != 16'h0000
        |-> clear_fault_pulse || $past(clear_fault_pulse);
    endproperty
    a_auto_hold: assert property (p_auto_hold)
        else $error("auto mask bit cleared without clear fault");

    property p_clr_empty;
        clear_fault_pulse |-> ##[0:1] auto_ack_suppress == 16'h0000;
    endproperty
    a_clr_empty: assert property (p_clr_empty)
        else $error("clear fault left auto mask set");

    property p_tmo_min;
        bus_timeout_pulse |-> low_ff >= 25 * MS;
    endproperty
    a_tmo_min: assert property (p_tmo_min)
        else $error("timeout before minimum low time");

    property p_tmo_rel;
        bus_timeout_pulse |-> ##[0:1] s_release [*3];
    endproperty
    a_tmo_rel: assert property (p_tmo_rel)
        else $error("lines held after timeout");

    property p_tmo_max;
        low_ff > 35 * MS |-> s_release;
    endproperty
    a_tmo_max: assert property (p_tmo_max)
        else $error("lines held past maximum timeout");

    property p_budget;
        st_ff <= 25 * MS;
    endproperty
    a_budget: assert property (p_budget)
        else $error("stretch budget exceeded");

    property p_abort;
        stretch_abort_pulse |-> (st_ff >= 23 * MS) ##[0:1] s_release [*3];
    endproperty
    a_abort: assert property (p_abort)
        else $error("stretch abort early or lines kept");
endmodule : smbat_checker

bind smbat_top smbat_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
    .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
    .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
    .alert_request_line_oe_n(alert_request_line_oe_n),
    .fault_active(fault_active), .clear_fault_pulse(clear_fault_pulse),
    .alert_suppress_mask(alert_suppress_mask),
    .auto_ack_suppress(auto_ack_suppress),
    .bus_timeout_pulse(bus_timeout_pulse),
    .stretch_abort_pulse(stretch_abort_pulse)
);

// ---- test/smbat_top_test.sv ----
// Purpose: self-checking bench of the alert and timeout block
// Assumes: one ms scaled to 40 clock cycles
// Notes: host model drives the link; bench drives faults and straps
`timescale 1ns/100ps
module smbat_top_test;
    localparam int CPM = 40;
    logic clk;
    logic rstn;
    logic scl_rel;
    logic sda_rel;
    logic rival_n;
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
    logic al_out;
    logic al_oe_n;
    logic [1:0] pin0;
    logic [1:0] pin1;
    logic [1:0] pin2;
    logic [15:0] fault;
    logic busy;
    logic clr;
    logic tmo;
    logic abt;
    logic [15:0] mask;
    logic [15:0] auto_m;
    logic [15:0] v;
    logic [7:0] rd;
    logic ack;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_clr = 0;
    int n_tmo = 0;
    int n_abt = 0;
    logic [5:0] pins [3] = '{6'h00, 6'h25, 6'h1b};
    logic [6:0] adr [3] = '{7'h40, 7'h56, 7'h17};
    // pulled-up open-drain wires
    wire scl = scl_rel & (scl_oe_n | scl_out);
    wire sda = sda_rel & rival_n & (sda_oe_n | sda_out);
    wire alert_wire = al_oe_n | al_out;

    smbat_top #(.CYCLES_PER_MS(CPM)) uut (
        .clk(clk), .rstn(rstn), .scl_in(scl), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .alert_request_line_out(al_out),
        .alert_request_line_oe_n(al_oe_n), .addr_sel_pin_0(pin0),
        .addr_sel_pin_1(pin1), .addr_sel_pin_2(pin2),
        .fault_active(fault), .core_busy(busy), .clear_fault_pulse(clr),
        .alert_suppress_mask(mask), .auto_ack_suppress(auto_m),
        .bus_timeout_pulse(tmo), .stretch_abort_pulse(abt)
    );

    smbat_host host (
        .scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        n_clr <= n_clr + int'(clr);
        n_tmo <= n_tmo + int'(tmo);
        n_abt <= n_abt + int'(abt);
        if (cyc == 50000)
        begin
            err_count++;
            $display("mismatch %0t timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [31:0] d,
        input int n, input logic p);
        host.start();
        host.xfer({a, 1'b0}, 1'b1, rd, ack);
        chk({15'h0, ack}, 16'h0000);
        for (int i = 0; i < n; i++)
        begin
            host.xfer(d[8 * i +: 8], 1'b1, rd, ack);
            chk({15'h0, ack}, 16'h0000);
        end
        if (p)
        begin
            host.stop();
        end
    endtask : wr

    task automatic rd_word(input logic [6:0] a, output logic [15:0] r);
        logic [7:0] lo;
        wr(a, 32'hd8, 1, 1'b0);
        host.start();
        host.xfer({a, 1'b1}, 1'b1, rd, ack);
        host.xfer(8'hff, 1'b0, lo, ack);
        host.xfer(8'hff, 1'b1, rd, ack);
        host.stop();
        r = {rd, lo};
    endtask : rd_word

    task automatic ara(input logic rv);
        host.start();
        host.xfer(8'h19, 1'b1, rd, ack);
        chk({15'h0, ack}, 16'h0000);
        rival_n = !rv;
        host.xfer(8'hff, 1'b1, rd, ack);
        rival_n = 1'b1;
        host.stop();
        repeat (4) @(negedge clk);
    endtask : ara

    task automatic end_sim();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial
    begin
        rstn = 1'b0;
        fault = 16'h0000;
        busy = 1'b0;
        {pin2, pin1, pin0} = 6'h00;
        rival_n = 1'b1;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk(mask, 16'h0000);
        chk({auto_m[14:0], al_oe_n}, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            {pin2, pin1, pin0} = pins[i];
            repeat (6) @(negedge clk);
            wr(adr[i], 32'h0, 0, 1'b1);
        end
        {pin2, pin1, pin0} = 6'h00;
        host.start();
        host.xfer(8'h82, 1'b1, rd, ack);
        chk({15'h0, ack}, 16'h0001);
        host.stop();
        wr(7'h40, {8'h00, 16'ha5c3, 8'hd8}, 3, 1'b1);
        chk(mask, 16'ha5c3);
        rd_word(7'h40, v);
        chk(v, 16'ha5c3);
        wr(7'h40, {8'h00, 16'h0004, 8'hd8}, 3, 1'b1);
        fault = 16'h0004;
        repeat (4) @(negedge clk);
        chk({15'h0, alert_wire}, 16'h0001);
        wr(7'h40, {8'h00, 16'h0000, 8'hd8}, 3, 1'b1);
        chk({15'h0, alert_wire}, 16'h0000);
        ara(1'b1);
        chk({rd, auto_m[7:0]}, 16'h0000);
        chk({15'h0, alert_wire}, 16'h0000);
        ara(1'b0);
        chk({8'h00, rd}, 16'h0080);
        chk(auto_m, 16'h0004);
        chk({15'h0, alert_wire}, 16'h0001);
        fault = 16'h000c;
        repeat (4) @(negedge clk);
        chk({15'h0, alert_wire}, 16'h0000);
        fault = 16'h0004;
        repeat (4) @(negedge clk);
        chk({15'h0, alert_wire}, 16'h0001);
        wr(7'h40, 32'h03, 1, 1'b1);
        chk(n_clr[15:0], 16'h0001);
        chk({auto_m[14:0], alert_wire}, 16'h0000);
        fault = 16'h0000;
        wr(7'h40, 32'h0, 0, 1'b0);
        #(30 * CPM * 25);
        chk(n_tmo[15:0], 16'h0001);
        host.stop();
        busy = 1'b1;
        wr(7'h40, 32'h0, 0, 1'b0);
        #(30 * CPM * 25);
        chk({n_tmo[7:0], n_abt[7:0]}, 16'h0101);
        busy = 1'b0;
        host.stop();
        rd_word(7'h40, v);
        chk(v, 16'h0000);
        end_sim();
    end
endmodule : smbat_top_test
